// File: rtl/sdc_top.sv
// step and direction command decoder with an AXI4-Lite register slave
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "sdc_params.svh"
// Behaviours
// Behaviour
// R01: single mode steps on chosen step edge
// R02: single mode direction line level picks rotation
// R03: dual mode step line pulses step clockwise
// R04: dual mode direction line pulses step counter-clockwise
// R05: controller holds step pulse over 7.5 us
// R06: controller sets direction 5 us before edge
// R07: gate high enables drive, low disables
// R08: undriven gate line counts as enabled
// R09: defaults are single mode, rising edge
// R10: controller changes gate 5 us before direction
// R11: controller keeps step low 7.5 us
// R12: synchronise inputs, one step per edge; coincident dual mode edges on both lines give no step
module sdc_top #(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // command lines
  input wire logic step_pulse_in_i,
  input wire logic direction_in_i,
  input wire logic drive_gate_in_i,
  // motion outputs
  output logic step_o,
  output logic dir_o,
  output logic enabled_o,
  // axi4-lite write
  input wire logic [`SDC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`SDC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  sdc_sync_if #(.NCH(`SDC_NUM_CH)) sync ();
  sdc_pkg::sdc_mode_t cfg_mode;
  sdc_pkg::sdc_pol_t cfg_pol;
  logic [POS_W-1:0] pos;
  logic [`SDC_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic step_edge;
  logic dir_edge;
  logic next_step;
  logic next_dir;

  sdc_sync #(.NCH(`SDC_NUM_CH), .RST_VAL(`SDC_SYNC_RST)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i({drive_gate_in_i, direction_in_i, step_pulse_in_i}),
    .sync(sync)
  );

  // leading edge into the active level; falling polarity means active-low pulses
  assign step_edge = (cfg_pol == sdc_pkg::sdc_pol_falling) ?
    sync.fall[`SDC_CH_STEP] : sync.rise[`SDC_CH_STEP]; // R01 R03
  assign dir_edge = (cfg_pol == sdc_pkg::sdc_pol_falling) ?
    sync.fall[`SDC_CH_DIR] : sync.rise[`SDC_CH_DIR]; // R04

  always_comb begin
    next_step = 1'b0;
    next_dir = dir_o;
    if (cfg_mode == sdc_pkg::single_pulse_mode) begin
      next_step = step_edge; // R01
      next_dir = sync.lvl[`SDC_CH_DIR]; // R02
    end else if (step_edge != dir_edge) begin
      // coincident pulses on both lines cancel rather than pick a winner
      next_step = 1'b1;
      next_dir = step_edge; // R03 R04
    end
    if (!sync.lvl[`SDC_CH_GATE]) begin
      next_step = 1'b0; // R07
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      step_o <= 1'b0;
      dir_o <= 1'b1;
      enabled_o <= 1'b1; // R08
    end else begin
      step_o <= next_step;
      dir_o <= next_dir;
      enabled_o <= sync.lvl[`SDC_CH_GATE]; // R07
    end
  end

  // position follows the issued steps, clockwise counts up
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos <= '0;
    end else if (next_step) begin
      pos <= next_dir ? pos + POS_W'(1) : pos - POS_W'(1);
    end
  end

  // write address and data are caught in either order
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= '0;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got && !s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (aw_got && w_got) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got && !s_axi_bvalid;
      if (s_axi_wready && s_axi_wvalid) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (aw_got && w_got) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_mode <= sdc_pkg::single_pulse_mode; // R09
      cfg_pol <= sdc_pkg::sdc_pol_rising; // R09
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDC_RESP_OKAY;
    end else if (aw_got && w_got) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `SDC_RESP_OKAY;
      if (aw_addr[`SDC_ADDR_W-1:2] == `SDC_REG_CFG >> 2) begin
        if (w_strb[0]) begin
          cfg_mode <= sdc_pkg::sdc_mode_t'(w_data[`SDC_CFG_MODE_BIT]);
          cfg_pol <= sdc_pkg::sdc_pol_t'(w_data[`SDC_CFG_POL_BIT]);
        end
      end else if (aw_addr[`SDC_ADDR_W-1:2] != `SDC_REG_STATUS >> 2 &&
                   aw_addr[`SDC_ADDR_W-1:2] != `SDC_REG_POS >> 2) begin
        s_axi_bresp <= `SDC_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SDC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SDC_RESP_OKAY;
        s_axi_rdata <= '0;
        unique case (s_axi_araddr[`SDC_ADDR_W-1:2])
          `SDC_REG_CFG >> 2: begin
            s_axi_rdata[`SDC_CFG_MODE_BIT] <= cfg_mode;
            s_axi_rdata[`SDC_CFG_POL_BIT] <= cfg_pol;
          end
          `SDC_REG_STATUS >> 2: begin
            s_axi_rdata[`SDC_ST_GATE_BIT] <= enabled_o;
            s_axi_rdata[`SDC_ST_DIR_BIT] <= dir_o;
          end
          `SDC_REG_POS >> 2: begin
            s_axi_rdata[POS_W-1:0] <= pos;
          end
          default: begin
            s_axi_rresp <= `SDC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // step output lands three cycles after the raw line changes
  sequence step_rise_s;
    !step_pulse_in_i ##1 step_pulse_in_i;
  endsequence

  sequence quiet_single_s;
    (cfg_mode == sdc_pkg::single_pulse_mode && cfg_pol == sdc_pkg::sdc_pol_rising)[*2];
  endsequence

  step_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R01
    step_o && $past(cfg_mode) == sdc_pkg::single_pulse_mode |->
      $past(step_pulse_in_i, 3) != $past(step_pulse_in_i, 4) &&
      $past(step_pulse_in_i, 3) == ($past(cfg_pol) == sdc_pkg::sdc_pol_rising))
    else $error("single mode step without matching edge");

  step_issue_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R01
    step_rise_s ##0 drive_gate_in_i ##1 quiet_single_s |-> ##1 step_o)
    else $error("rising step edge gave no step");

  dir_level_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R02
    step_o && $past(cfg_mode) == sdc_pkg::single_pulse_mode |->
      dir_o == $past(direction_in_i, 3))
    else $error("direction does not follow line level");

  cw_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R03
    step_o && dir_o && $past(cfg_mode) == sdc_pkg::dual_pulse_mode |->
      $past(step_pulse_in_i, 3) == ($past(cfg_pol) == sdc_pkg::sdc_pol_rising) &&
      $past(step_pulse_in_i, 4) != $past(step_pulse_in_i, 3))
    else $error("clockwise step without step line pulse");

  ccw_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R04
    step_o && !dir_o && $past(cfg_mode) == sdc_pkg::dual_pulse_mode |->
      $past(direction_in_i, 3) == ($past(cfg_pol) == sdc_pkg::sdc_pol_rising) &&
      $past(direction_in_i, 4) != $past(direction_in_i, 3))
    else $error("counter-clockwise step without direction line pulse");

  gate_block_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R07
    step_o |-> $past(drive_gate_in_i, 3) && enabled_o)
    else $error("step issued while gated off");

  gate_default_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R08
    $fell(rst_i) |-> enabled_o [*3])
    else $error("drive not enabled before gate line is seen");

  cfg_default_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R09
    $fell(rst_i) |-> cfg_mode == sdc_pkg::single_pulse_mode &&
      cfg_pol == sdc_pkg::sdc_pol_rising && !step_o)
    else $error("wrong configuration after reset");

  one_step_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    step_o |=> !step_o)
    else $error("one edge gave more than one step");
endmodule

// File: rtl/sdc_params.svh
// constants of the step and direction command decoder
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
`define SDC_ADDR_W 8
`define SDC_REG_CFG 8'h00
`define SDC_REG_STATUS 8'h04
`define SDC_REG_POS 8'h08
`define SDC_CFG_MODE_BIT 0
`define SDC_CFG_POL_BIT 1
`define SDC_ST_GATE_BIT 0
`define SDC_ST_DIR_BIT 1
`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2
`define SDC_NUM_CH 3
`define SDC_CH_STEP 0
`define SDC_CH_DIR 1
`define SDC_CH_GATE 2
// gate channel resets high so a line nobody drives counts as enabled
`define SDC_SYNC_RST 3'h4
`endif

// File: rtl/sdc_pkg.sv
// types of the step and direction command decoder
package sdc_pkg;
  typedef enum logic {
    single_pulse_mode = 1'b0,
    dual_pulse_mode = 1'b1
  } sdc_mode_t;
  typedef enum logic {
    sdc_pol_rising = 1'b0,
    sdc_pol_falling = 1'b1
  } sdc_pol_t;
endpackage

// File: rtl/sdc_sync_if.sv
// synchronised levels and edges passed from the input stage to the decoder
`timescale 1ns/1ps
interface sdc_sync_if #(parameter int NCH = 3);
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// File: rtl/sdc_sync.sv
// input synchronisers and edge detectors, one per command line
`timescale 1ns/1ps
`include "sdc_params.svh"
module sdc_sync #(
  parameter int NCH = `SDC_NUM_CH,
  parameter logic [NCH-1:0] RST_VAL = `SDC_SYNC_RST
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // raw lines
  input wire logic [NCH-1:0] raw_i,
  // synchronised view
  sdc_sync_if.src sync
);
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic meta;
      logic stable;
      logic last;
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          meta <= RST_VAL[g];
          stable <= RST_VAL[g];
          last <= RST_VAL[g];
        end else begin
          meta <= raw_i[g];
          stable <= meta;
          last <= stable;
        end
      end
      // only the second and third stages feed the edge logic
      assign sync.lvl[g] = stable;
      assign sync.rise[g] = stable & ~last; // R12
      assign sync.fall[g] = ~stable & last; // R12
    end
  endgenerate
endmodule

// File: dv/sdc_ctl_model.sv
// motion controller model driving the step, direction and gate lines
`timescale 1ns/1ps
module sdc_ctl_model (
  // clock
  input wire logic mclk_i,
  // command lines
  output logic step_o,
  output logic dir_o,
  output tri1 gate_o
);
  logic gate_en = 1'h0;
  logic gate_v = 1'h1;
  // released gate floats to the pad pull, which reads as enabled
  assign gate_o = gate_en ? gate_v : 1'bz;
  initial begin
    step_o = 1'h0;
    dir_o = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic set_gate(input logic en, input logic v);
    gate_en <= en;
    gate_v <= v;
    hold(260);
  endtask
  task automatic set_idle(input logic v);
    step_o <= v;
    dir_o <= v;
    hold(260);
  endtask
  // one pulse at level act, each phase a little over 7.5 us
  task automatic pulse(input logic ccw, input logic act);
    if (ccw) dir_o <= act; else step_o <= act;
    hold(380);
    if (ccw) dir_o <= ~act; else step_o <= ~act;
    hold(380);
  endtask
  task automatic single(input logic d);
    dir_o <= d;
    hold(260);
    pulse(1'h0, 1'h1);
  endtask
endmodule

// File: dv/sdc_top_tb.sv
// self-checking bench of the step and direction command decoder
`timescale 1ns/1ps
`include "sdc_params.svh"
module sdc_top_tb;
  typedef struct {logic [31:0] cfg; logic ccw; logic lvl; logic dir; logic [31:0] dp;} sdc_row_t;
  // cfg, ccw line, level, expected direction, position change
  sdc_row_t rows [8] = '{
    '{32'h0, 1'h0, 1'h1, 1'h1, 32'h1}, '{32'h0, 1'h0, 1'h0, 1'h0, 32'hFFFFFFFF},
    '{32'h2, 1'h0, 1'h1, 1'h1, 32'h1}, '{32'h2, 1'h0, 1'h0, 1'h0, 32'hFFFFFFFF},
    '{32'h1, 1'h0, 1'h1, 1'h1, 32'h1}, '{32'h1, 1'h1, 1'h1, 1'h0, 32'hFFFFFFFF},
    '{32'h3, 1'h0, 1'h0, 1'h1, 32'h1}, '{32'h3, 1'h1, 1'h0, 1'h0, 32'hFFFFFFFF}};
  logic mclk_i, rst_i, step_l, dir_l, step_o, dir_o, enabled_o, last_dir;
  tri1 gate_l;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, p0, p1;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  int n_errors = 0;
  int tests_run = 0;
  int n_steps = 0;
  int n0;
  sdc_ctl_model ctl_u (.mclk_i(mclk_i), .step_o(step_l), .dir_o(dir_l), .gate_o(gate_l));
  sdc_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .step_pulse_in_i(step_l),
    .direction_in_i(dir_l), .drive_gate_in_i(gate_l), .step_o(step_o), .dir_o(dir_o),
    .enabled_o(enabled_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end
  // sampled mid-cycle so the design's edge updates have landed
  always @(negedge mclk_i) if (step_o === 1'h1) begin
    n_steps <= n_steps + 1;
    last_dir <= dir_o;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // handshakes are judged at the rising edge itself; only the watchdog ends a wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge mclk_i);
      if (!aw && awready === 1'h1) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w && wready === 1'h1) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do begin
      @(posedge mclk_i);
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
    // one idle edge so a following call never drives bready twice in one step
    @(posedge mclk_i);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk_i);
    end while (arready !== 1'h1);
    arvalid <= 1'h0;
    do begin
      @(posedge mclk_i);
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge mclk_i);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, p1, rs);
    chk(nm, e, p1);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'h1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge mclk_i);
    chk("reset_outputs", 32'h3, {step_o, dir_o, enabled_o});
    rst_i <= 1'h0;
    ctl_u.hold(2);
    rd_chk("cfg_default", `SDC_REG_CFG, 32'h0);
    rd_chk("status_undriven_gate", `SDC_REG_STATUS, 32'h1);
    n0 = n_steps;
    ctl_u.single(1'h1);
    chk("default_edge_steps", 32'h1, 32'(n_steps - n0));
    foreach (rows[i]) begin
      axi_wr(`SDC_REG_CFG, rows[i].cfg, rs);
      ctl_u.set_idle(rows[i].cfg[0] & rows[i].cfg[1]);
      axi_rd(`SDC_REG_POS, p0, rs);
      n0 = n_steps;
      if (rows[i].cfg[0]) ctl_u.pulse(rows[i].ccw, rows[i].lvl);
      else ctl_u.single(rows[i].lvl);
      chk("step_count", 32'h1, 32'(n_steps - n0));
      chk("step_dir", 32'(rows[i].dir), 32'(last_dir));
      rd_chk("position", `SDC_REG_POS, p0 + rows[i].dp);
    end
    axi_wr(`SDC_REG_CFG, 32'h0, rs);
    // lines low first, so the gated pulse below really offers a rising edge
    ctl_u.set_idle(1'h0);
    ctl_u.set_gate(1'h1, 1'h0);
    rd_chk("status_gated", `SDC_REG_STATUS, 32'h0);
    axi_rd(`SDC_REG_POS, p0, rs);
    n0 = n_steps;
    ctl_u.single(1'h1);
    chk("gated_steps", 32'h0, 32'(n_steps - n0));
    rd_chk("gated_position", `SDC_REG_POS, p0);
    ctl_u.set_gate(1'h1, 1'h1);
    rd_chk("status_enabled", `SDC_REG_STATUS, 32'h3);
    axi_rd(8'h0C, p1, rs);
    chk("unmapped_rresp", 32'(`SDC_RESP_SLVERR), 32'(rs));
    chk("unmapped_rdata", 32'h0, p1);
    axi_wr(8'h10, 32'hFFFFFFFF, rs);
    chk("unmapped_bresp", 32'(`SDC_RESP_SLVERR), 32'(rs));
    axi_wr(`SDC_REG_STATUS, 32'hFFFFFFFF, rs);
    chk("status_write_bresp", 32'(`SDC_RESP_OKAY), 32'(rs));
    axi_wr(`SDC_REG_CFG, 32'h3, rs);
    rst_i <= 1'h1;
    ctl_u.hold(4);
    rst_i <= 1'h0;
    ctl_u.hold(2);
    rd_chk("cfg_after_reset", `SDC_REG_CFG, 32'h0);
    rd_chk("pos_after_reset", `SDC_REG_POS, 32'h0);
    report_and_stop();
  end
endmodule
